// file: verilog/event_id_pkg.sv
`default_nettype none
package event_id_pkg;
	// Access decode fields of the identification register
	localparam logic [1:0] SYS_OP0      = 2'h3;
	localparam logic [2:0] SYS_OP1      = 3'h3;
	localparam logic [3:0] SYS_CRN      = 4'h9;
	localparam logic [3:0] SYS_CRM      = 4'hC;
	localparam logic [2:0] SYS_OP2      = 3'h7;
	// Syndrome class for trapped monitor accesses
	localparam logic [5:0] TRAP_SYNDROME = 6'h18;
	// Fixed parts of the register value
	localparam logic [31:0] HIGH_FIXED  = 32'h0000_0077;
	localparam logic [31:0] LOW_FIXED   = 32'hFFF0_A07E;
	localparam int          L3_BIT_POS  = 11;
	localparam int          L2_BIT_POS  = 0;
	// Exception levels
	localparam logic [1:0] LEVEL_0 = 2'h0;
	localparam logic [1:0] LEVEL_1 = 2'h1;
	localparam logic [1:0] LEVEL_2 = 2'h2;
	localparam logic [1:0] LEVEL_3 = 2'h3;
	typedef enum logic [1:0] {
		RESULT_NONE,
		RESULT_VALUE,
		RESULT_TRAP,
		RESULT_UNDEF
	} result_t;
endpackage
`default_nettype wire

// file: verilog/common_event_id_high.sv
`default_nettype none
module common_event_id_high
	import event_id_pkg::*;
(
	input  wire logic                 clk_in,
	input  wire logic                 reset_in,
	input  wire logic                 l2_present_in,
	input  wire logic                 l3_present_in,
	input  wire logic                 read_valid_in,
	input  wire logic [1:0]           op0_in,
	input  wire logic [2:0]           op1_in,
	input  wire logic [3:0]           crn_in,
	input  wire logic [3:0]           crm_in,
	input  wire logic [2:0]           op2_in,
	input  wire logic [1:0]           current_level_in,
	input  wire logic                 halted_in,
	input  wire logic                 secure_debug_disable_in,
	input  wire logic                 monitor_pmu_trap_in,
	input  wire logic                 hyp_pmu_trap_in,
	input  wire logic                 level2_enabled_in,
	input  wire logic                 fine_trap_enable_in,
	input  wire logic                 fine_read_trap_eventid_in,
	input  wire logic                 user_access_enable_in,
	input  wire logic                 host_trap_general_in,
	output logic                      hit_out,
	output logic                      done_out,
	output logic [1:0]                result_out,
	output logic [1:0]                trap_level_out,
	output logic [5:0]                syndrome_out,
	output logic [63:0]               read_data_out,
	output logic [31:0]               external_event_id_low_copy_out,
	output logic [31:0]               external_event_id_high_copy_out
);
	import event_id_pkg::*;

	// ==========================================================
	// Register value
	// ==========================================================
	logic [31:0] lower_event_flag;
	logic [31:0] upper_event_flag;
	logic        l3_event_bit;

	// Cache options are straps, so the value is combinational on them
	assign l3_event_bit = l2_present_in & l3_present_in;
	assign upper_event_flag = HIGH_FIXED;
	always_comb
	begin
		lower_event_flag = LOW_FIXED;
		lower_event_flag[L3_BIT_POS] = l3_event_bit;
		lower_event_flag[L2_BIT_POS] = l2_present_in;
	end

	// External copies share the same bits so they cannot drift apart
	assign external_event_id_low_copy_out  = lower_event_flag;
	assign external_event_id_high_copy_out = upper_event_flag;

	// ==========================================================
	// Access decode and permission chain
	// ==========================================================
	logic    decode_hit;
	logic    halt_block;
	logic    fine_trap;
	logic    hyp_trap;
	logic    user_trap;
	result_t result_next;
	logic [1:0] level_next;

	assign decode_hit = read_valid_in && op0_in == SYS_OP0
		&& op1_in == SYS_OP1 && crn_in == SYS_CRN
		&& crm_in == SYS_CRM && op2_in == SYS_OP2;
	assign halt_block = halted_in & secure_debug_disable_in;
	assign fine_trap  = level2_enabled_in & fine_trap_enable_in
		& fine_read_trap_eventid_in;
	assign hyp_trap   = level2_enabled_in & hyp_pmu_trap_in;
	assign user_trap  = ~user_access_enable_in;

	always_comb
	begin
		result_next = RESULT_VALUE;
		level_next  = LEVEL_0;
		case (current_level_in)
			LEVEL_0, LEVEL_1:
			begin
				if (halt_block && monitor_pmu_trap_in)
					result_next = RESULT_UNDEF;
				else if (current_level_in == LEVEL_0 && user_trap)
				begin
					result_next = RESULT_TRAP;
					level_next  = (level2_enabled_in
						&& host_trap_general_in) ? LEVEL_2 : LEVEL_1;
				end
				else if (fine_trap)
				begin
					result_next = RESULT_TRAP;
					level_next  = LEVEL_2;
				end
				else if (hyp_trap)
				begin
					result_next = RESULT_TRAP;
					level_next  = LEVEL_2;
				end
				else if (monitor_pmu_trap_in)
				begin
					result_next = RESULT_TRAP;
					level_next  = LEVEL_3;
				end
			end
			LEVEL_2:
			begin
				if (monitor_pmu_trap_in && halt_block)
					result_next = RESULT_UNDEF;
				else if (monitor_pmu_trap_in)
				begin
					result_next = RESULT_TRAP;
					level_next  = LEVEL_3;
				end
			end
			LEVEL_3:
				result_next = RESULT_VALUE;
			default:
				result_next = RESULT_NONE;
		endcase
	end

	// ==========================================================
	// Answer selection
	// ==========================================================
	logic        done_reg;
	logic        done_next;
	logic        hit_reg;
	logic        hit_next;
	logic [1:0]  result_reg;
	logic [1:0]  answer_next;
	logic [1:0]  target_reg;
	logic [1:0]  target_next;
	logic [5:0]  syndrome_reg;
	logic [5:0]  syndrome_next;
	logic [63:0] data_reg;
	logic [63:0] data_next;

	// The syndrome follows the answer, so a stale code cannot leak out
	function automatic logic [5:0] syndrome_for(input logic [1:0] answer);
		syndrome_for = (answer == RESULT_TRAP) ? TRAP_SYNDROME : 6'h00;
	endfunction

	// Data only leaves on a permitted read
	function automatic logic [63:0] data_for(
		input logic [1:0]  answer,
		input logic [31:0] upper,
		input logic [31:0] lower
	);
		data_for = (answer == RESULT_VALUE) ? {upper, lower}
			: 64'h0000_0000_0000_0000;
	endfunction

	assign done_next     = read_valid_in;
	assign hit_next      = decode_hit;
	assign answer_next   = decode_hit ? result_next : RESULT_NONE;
	assign target_next   = decode_hit ? level_next : LEVEL_0;
	assign syndrome_next = syndrome_for(answer_next);
	assign data_next     = data_for(answer_next, upper_event_flag,
		lower_event_flag);

	// ==========================================================
	// Registered answer
	// ==========================================================
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			done_reg <= 1'b0;
		else
			done_reg <= done_next;
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			hit_reg <= 1'b0;
		else
			hit_reg <= hit_next;
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			result_reg <= RESULT_NONE;
		else
			result_reg <= answer_next;
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			target_reg <= LEVEL_0;
		else
			target_reg <= target_next;
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			syndrome_reg <= 6'h00;
		else
			syndrome_reg <= syndrome_next;
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			data_reg <= 64'h0000_0000_0000_0000;
		else
			data_reg <= data_next;
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign done_out       = done_reg;
	assign hit_out        = hit_reg;
	assign result_out     = result_reg;
	assign trap_level_out = target_reg;
	assign syndrome_out   = syndrome_reg;
	assign read_data_out  = data_reg;
endmodule
`default_nettype wire

// file: tb/event_id_props.sv
`default_nettype none
module event_id_props
	import event_id_pkg::*;
(
	input wire logic        clk_in, reset_in, read_valid_in, hit_out,
	input wire logic        l2_present_in, l3_present_in, done_out,
	input wire logic [1:0]  current_level_in, result_out, trap_level_out,
	input wire logic [5:0]  syndrome_out,
	input wire logic [63:0] read_data_out,
	input wire logic [31:0] external_event_id_low_copy_out,
	input wire logic [31:0] external_event_id_high_copy_out
);
	wire [31:0] lo = external_event_id_low_copy_out;
	wire [31:0] hi = external_event_id_high_copy_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_done_pulse: assert property (read_valid_in |=> done_out)
		else $error("request without done");
	a_idle_quiet: assert property (!read_valid_in |=> !done_out
		&& result_out == 2'h0 && read_data_out == 64'h0)
		else $error("answer without request");
	a_hit_done: assert property (hit_out |-> done_out)
		else $error("hit without done");
	a_low_copy: assert property (result_out == 2'h1 |->
		read_data_out[31:0] == lo) else $error("low half differs");
	a_high_copy: assert property (result_out == 2'h1 |->
		read_data_out[63:32] == hi) else $error("high half differs");
	a_high_fixed: assert property (hi == 32'h0000_0077)
		else $error("high copy wrong");
	a_low_fixed: assert property (
		(lo & 32'hFFFF_F7FE) == 32'hFFF0_A07E)
		else $error("low fixed bits wrong");
	a_cache_bits: assert property (lo[11] == (l2_present_in
		&& l3_present_in) && lo[0] == l2_present_in)
		else $error("cache bits wrong");
	a_top_level: assert property (read_valid_in
		&& current_level_in == 2'h3 ##1 hit_out |-> result_out == 2'h1)
		else $error("top level not served");
	a_trap_syndrome: assert property (result_out == 2'h2 |->
		syndrome_out == 6'h18 && trap_level_out != 2'h0)
		else $error("bad trap report");
	cover property (result_out == 2'h2);
	cover property (result_out == 2'h3);
	cover property (done_out && !hit_out);
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import event_id_pkg::*;
	localparam logic [15:0] ENC = {SYS_OP0, SYS_OP1, SYS_CRN,
		SYS_CRM, SYS_OP2};
	logic        clk_in = 0, reset_in = 1, valid = 0, hit, done;
	logic [1:0]  straps = 0, res, tl;
	logic [15:0] enc = 0;
	logic [10:0] ctl = 0;
	logic [5:0]  syn;
	logic [63:0] data;
	logic [31:0] lo, hi;
	int          bad_count = 0, checks_done = 0;
	common_event_id_high dut (.clk_in(clk_in), .reset_in(reset_in),
		.l2_present_in(straps[0]), .l3_present_in(straps[1]),
		.read_valid_in(valid), .op0_in(enc[15:14]), .op1_in(enc[13:11]),
		.crn_in(enc[10:7]), .crm_in(enc[6:3]), .op2_in(enc[2:0]),
		.current_level_in(ctl[10:9]), .halted_in(ctl[8]),
		.secure_debug_disable_in(ctl[7]), .monitor_pmu_trap_in(ctl[6]),
		.hyp_pmu_trap_in(ctl[5]), .level2_enabled_in(ctl[4]),
		.fine_trap_enable_in(ctl[3]), .fine_read_trap_eventid_in(ctl[2]),
		.user_access_enable_in(ctl[1]), .host_trap_general_in(ctl[0]),
		.hit_out(hit), .done_out(done), .result_out(res),
		.trap_level_out(tl), .syndrome_out(syn), .read_data_out(data),
		.external_event_id_low_copy_out(lo),
		.external_event_id_high_copy_out(hi));
	initial forever #5 clk_in = ~clk_in;
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] want);
		checks_done++;
		if (got !== want)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask
	// ====================
	// One read, judged one cycle after it is taken
	task rd(input logic [15:0] e, input logic [10:0] c, input logic [3:0] rt);
		logic [63:0] v;
		@(posedge clk_in);
		enc <= e;
		ctl <= c;
		valid <= 1'b1;
		@(posedge clk_in);
		valid <= 1'b0;
		#1;
		// Straps are settled here, a strap change made just before is seen
		v = {32'h0000_0077,
			32'hFFF0_A07E | {20'h0, &straps, 10'h0, straps[0]}};
		chk(done, 1'b1);
		chk(hit, e == ENC);
		chk(res, rt[3:2]);
		chk(tl, rt[1:0]);
		chk(syn, rt[3:2] == 2'h2 ? 6'h18 : 6'h0);
		chk(data, rt[3:2] == 2'h1 ? v : 64'h0);
		chk({hi, lo}, v);
	endtask
	task test_value;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_in);
			straps <= i[1:0];
			rd(ENC, 11'h7FF, 4'h4);
		end
		$display("value test ended");
	endtask
	task test_decode;
		int flips[5] = '{14, 11, 7, 3, 0};
		foreach (flips[k])
			rd(ENC ^ (16'h1 << flips[k]), 11'h7FF, 4'h0);
		$display("decode test ended");
	endtask
	// Packed as control, result, trap level
	task test_access;
		logic [14:0] t[15] = '{15'h3C2C, 15'h5C2C, 15'h21EA, 15'h232A,
			15'h24EB, 15'h342B, 15'h43E4, 15'h442B, 15'h7FF4, 15'h0009,
			15'h011A, 15'h032A, 15'h1C0C, 15'h0024, 15'h2024};
		foreach (t[k])
			rd(ENC, t[k][14:4], t[k][3:0]);
		$display("access test ended");
	endtask
	initial
	begin
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		test_value;
		test_decode;
		test_access;
		end_sim;
	end
	initial
	begin
		repeat (20000) @(posedge clk_in);
		bad_count++;
		end_sim;
	end
endmodule
bind common_event_id_high event_id_props u_props (.*);
`default_nettype wire
